//--- include/ast_cfg.svh
`ifndef AST_CFG_SVH
`define AST_CFG_SVH
`define AST_AW 8
`define AST_A_STAT 8'h00
`define AST_A_DATA 8'h04
`define AST_A_CR1 8'h08
`define AST_A_CR2 8'h0C
`define AST_A_BRR 8'h10
`define AST_A_ETPR 8'h14
`define AST_A_ERPR 8'h18
`define AST_ST_TXE 7
`define AST_ST_TC 6
`define AST_ST_RXF 5
`define AST_ST_OVR 3
`define AST_ST_NF 2
`define AST_ST_FE 1
`define AST_C1_R8 7
`define AST_C1_T8 6
`define AST_C1_M 4
`define AST_C2_TIE 7
`define AST_C2_TX_COMPLETE_IRQ_EN 6
`define AST_C2_RIE 5
`define AST_C2_TE 3
`define AST_C2_RE 2
`define AST_C2_SBK 0
`define AST_BR_PR 7:6
`define AST_BR_TR 5:3
`define AST_BR_RR 2:0
`define AST_RESP_OK 2'h0
`define AST_RESP_ERR 2'h2
`define AST_SMP_A 4'h7
`define AST_SMP_C 4'h9
`define AST_OS_LAST 4'hF
`define AST_STOP8 4'h9
`define AST_STOP9 4'hA
`define AST_FRM8 4'hA
`define AST_FRM9 4'hB
`endif

//--- include/ast_pkg.sv
`default_nettype none
package ast_pkg;
   typedef enum logic [2:0] {TX_OFF = 3'b001, TX_READY = 3'b010, TX_SHIFT = 3'b100} ast_tx_t;
   typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_BITS = 2'b10} ast_rx_t;
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } ast_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ast_axi_rsp_t;
   typedef struct packed {
      ast_axi_rsp_t rsp;
      logic aw_have, w_have;
      logic [7:0] aw_addr, w_data;
      logic w_lane;
      logic word_len9, tx_ninth_bit, rx_ninth_bit;
      logic tx_empty_irq_en, tx_complete_irq_en, rx_irq_en;
      logic tx_enable, rx_enable, send_break;
      logic [1:0] pr_sel;
      logic [2:0] tx_div_sel, rx_div_sel;
      logic [7:0] tx_fine_prescaler, rx_fine_prescaler;
      logic seen;
      logic tx_empty_flag, tx_complete_flag, rx_full_flag;
      logic ovr_flag, noise_flag, framing_error_flag, nf_hidden;
      ast_tx_t tst;
      logic en_prev, idle_pend, brk_sent, hold_full;
      logic [7:0] tx_hold_buffer;
      logic [10:0] tx_sh;
      logic [3:0] tx_cnt, tx_os;
      logic [19:0] tx_div;
      logic tx_pin, tx_oe;
      ast_rx_t rst;
      logic rx_prev, rx_noise;
      logic [19:0] rx_div;
      logic [3:0] rx_os, rx_idx;
      logic [1:0] rx_vote;
      logic [8:0] rx_sh;
      logic [7:0] rx_hold_buffer;
      logic irq;
   } ast_state_t;
endpackage : ast_pkg
`default_nettype wire

//--- hdl/ast_top.sv
`include "ast_cfg.svh"
`default_nettype none
module ast_top import ast_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire ast_axi_req_t axi_req,
   output ast_axi_rsp_t axi_rsp,
   input wire logic serial_rx_in,
   input wire logic cpu_irq_mask,
   output logic serial_tx_out,
   output logic serial_tx_oe,
   output logic irq
);
   ast_state_t s_q, s_d;
   logic wr_data, rd_data, rx_done, stop_ok;

   // Oversample divider limit: prescaler * 2^sel * fine - 1
   function automatic logic [19:0] div_lim(input logic [1:0] pr, input logic [2:0] sel,
                                           input logic [7:0] fine);
      logic [3:0] p;
      logic [19:0] b;
      p = (pr == 2'h0) ? 4'h1 : (pr == 2'h1) ? 4'h3 : (pr == 2'h2) ? 4'h4 : 4'hD;
      b = 20'({16'h0, p} << sel);
      div_lim = 20'(b * 20'((fine == 8'h0) ? 8'h1 : fine)) - 20'h1;
   endfunction : div_lim

   always_comb begin
      logic [7:0] rv;
      logic os_t, bit_t, in_bit, maj, noisy, ld;
      logic [3:0] n;
      logic [2:0] v;
      s_d = s_q;
      rv = 8'h0;
      wr_data = 1'b0;
      rd_data = 1'b0;
      rx_done = 1'b0;
      stop_ok = 1'b0;
      ld = 1'b0;
      n = s_q.word_len9 ? `AST_FRM9 : `AST_FRM8;
      // ---------------------------------------------------------------
      // Bus write side
      // ---------------------------------------------------------------
      if (s_q.rsp.bvalid && axi_req.bready) begin
         s_d.rsp.bvalid = 1'b0;
      end
      if (axi_req.awvalid && s_q.rsp.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && s_q.rsp.wready) begin
         s_d.w_have = 1'b1;
         s_d.w_data = axi_req.wdata[7:0];
         s_d.w_lane = axi_req.wstrb[0];
      end
      if (s_d.aw_have && s_d.w_have && !s_d.rsp.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp = `AST_RESP_OK;
         if (s_d.aw_addr == `AST_A_STAT) begin
            s_d.seen = 1'b1;
         end else if (s_d.aw_addr == `AST_A_DATA) begin
            if (s_d.w_lane) begin
               wr_data = 1'b1;
            end
         end else if (s_d.aw_addr == `AST_A_CR1) begin
            if (s_d.w_lane) begin
               s_d.tx_ninth_bit = s_d.w_data[`AST_C1_T8];
               s_d.word_len9 = s_d.w_data[`AST_C1_M];
            end
         end else if (s_d.aw_addr == `AST_A_CR2) begin
            if (s_d.w_lane) begin
               s_d.tx_empty_irq_en = s_d.w_data[`AST_C2_TIE];
               s_d.tx_complete_irq_en = s_d.w_data[`AST_C2_TX_COMPLETE_IRQ_EN];
               s_d.rx_irq_en = s_d.w_data[`AST_C2_RIE];
               s_d.tx_enable = s_d.w_data[`AST_C2_TE];
               s_d.rx_enable = s_d.w_data[`AST_C2_RE];
               s_d.send_break = s_d.w_data[`AST_C2_SBK];
            end
         end else if (s_d.aw_addr == `AST_A_BRR) begin
            if (s_d.w_lane) begin
               s_d.pr_sel = s_d.w_data[`AST_BR_PR];
               s_d.tx_div_sel = s_d.w_data[`AST_BR_TR];
               s_d.rx_div_sel = s_d.w_data[`AST_BR_RR];
            end
         end else if (s_d.aw_addr == `AST_A_ETPR) begin
            if (s_d.w_lane) begin
               s_d.tx_fine_prescaler = s_d.w_data;
            end
         end else if (s_d.aw_addr == `AST_A_ERPR) begin
            if (s_d.w_lane) begin
               s_d.rx_fine_prescaler = s_d.w_data;
            end
         end else begin
            s_d.rsp.bresp = `AST_RESP_ERR;
         end
      end
      // ---------------------------------------------------------------
      // Bus read side
      // ---------------------------------------------------------------
      if (s_q.rsp.rvalid && axi_req.rready) begin
         s_d.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && s_q.rsp.arready) begin
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rresp = `AST_RESP_OK;
         if (axi_req.araddr == `AST_A_STAT) begin
            rv[`AST_ST_TXE] = s_q.tx_empty_flag;
            rv[`AST_ST_TC] = s_q.tx_complete_flag;
            rv[`AST_ST_RXF] = s_q.rx_full_flag;
            rv[`AST_ST_OVR] = s_q.ovr_flag;
            rv[`AST_ST_NF] = s_q.noise_flag;
            rv[`AST_ST_FE] = s_q.framing_error_flag;
            s_d.seen = 1'b1;
         end else if (axi_req.araddr == `AST_A_DATA) begin
            rv = s_q.rx_hold_buffer;
            rd_data = 1'b1;
         end else if (axi_req.araddr == `AST_A_CR1) begin
            rv[`AST_C1_R8] = s_q.rx_ninth_bit;
            rv[`AST_C1_T8] = s_q.tx_ninth_bit;
            rv[`AST_C1_M] = s_q.word_len9;
         end else if (axi_req.araddr == `AST_A_CR2) begin
            rv[`AST_C2_TIE] = s_q.tx_empty_irq_en;
            rv[`AST_C2_TX_COMPLETE_IRQ_EN] = s_q.tx_complete_irq_en;
            rv[`AST_C2_RIE] = s_q.rx_irq_en;
            rv[`AST_C2_TE] = s_q.tx_enable;
            rv[`AST_C2_RE] = s_q.rx_enable;
            rv[`AST_C2_SBK] = s_q.send_break;
         end else if (axi_req.araddr == `AST_A_BRR) begin
            rv = {s_q.pr_sel, s_q.tx_div_sel, s_q.rx_div_sel};
         end else if (axi_req.araddr == `AST_A_ETPR) begin
            rv = s_q.tx_fine_prescaler;
         end else if (axi_req.araddr == `AST_A_ERPR) begin
            rv = s_q.rx_fine_prescaler;
         end else begin
            s_d.rsp.rresp = `AST_RESP_ERR;
         end
         s_d.rsp.rdata = {24'h0, rv};
      end
      // ---------------------------------------------------------------
      // Flag clear sequences; hardware sets below win
      // ---------------------------------------------------------------
      if (wr_data && s_q.seen) begin
         s_d.tx_empty_flag = 1'b0;
         s_d.tx_complete_flag = 1'b0;
      end
      if (rd_data && s_q.seen) begin
         s_d.rx_full_flag = 1'b0;
         s_d.ovr_flag = 1'b0;
         s_d.noise_flag = 1'b0;
         s_d.framing_error_flag = 1'b0;
      end
      if (wr_data || rd_data) begin
         s_d.seen = 1'b0;
      end
      // ---------------------------------------------------------------
      // Transmitter
      // ---------------------------------------------------------------
      os_t = 1'b0;
      if (!s_q.tx_enable) begin
         s_d.tx_div = 20'h0;
         s_d.tx_os = 4'h0;
      end else if (s_q.tx_div == div_lim(s_q.pr_sel, s_q.tx_div_sel, s_q.tx_fine_prescaler)) begin
         s_d.tx_div = 20'h0;
         s_d.tx_os = s_q.tx_os + 4'h1;
         os_t = 1'b1;
      end else begin
         s_d.tx_div = s_q.tx_div + 20'h1;
      end
      bit_t = os_t && (s_q.tx_os == `AST_OS_LAST);
      if (wr_data) begin
         if (s_q.tst == TX_READY && s_q.tx_enable && !s_q.idle_pend && !s_q.send_break
             && !s_q.brk_sent) begin
            s_d.tx_sh = {1'b1, s_q.word_len9 ? s_q.tx_ninth_bit : 1'b1, s_d.w_data, 1'b0};
            s_d.tx_cnt = n;
            s_d.tst = TX_SHIFT;
            s_d.tx_empty_flag = 1'b1;
         end else begin
            s_d.tx_hold_buffer = s_d.w_data;
            s_d.hold_full = 1'b1;
         end
      end
      s_d.en_prev = s_q.tx_enable;
      if (s_q.tx_enable != s_q.en_prev) begin
         s_d.hold_full = 1'b0;
         if (s_q.tx_enable) begin
            s_d.idle_pend = 1'b1;
         end
      end
      case (s_q.tst)
         TX_OFF: begin
            if (s_q.tx_enable) begin
               s_d.tst = TX_READY;
            end
         end
         TX_READY: begin
            if (!s_q.tx_enable) begin
               s_d.tst = TX_OFF;
            end else if (bit_t) begin
               ld = 1'b1;
            end
         end
         TX_SHIFT: begin
            if (bit_t) begin
               if (s_q.tx_cnt != 4'h0) begin
                  s_d.tx_pin = s_q.tx_sh[0];
                  s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
                  s_d.tx_cnt = s_q.tx_cnt - 4'h1;
               end else begin
                  s_d.tx_complete_flag = 1'b1;
                  s_d.tx_pin = 1'b1;
                  s_d.tst = s_q.tx_enable ? TX_READY : TX_OFF;
                  ld = s_q.tx_enable;
               end
            end
         end
         default: begin
            s_d.tst = TX_OFF;
         end
      endcase
      if (ld) begin
         s_d.tst = TX_SHIFT;
         s_d.tx_cnt = n;
         if (s_d.idle_pend) begin
            s_d.idle_pend = 1'b0;
            s_d.tx_sh = 11'h7FF;
         end else if (s_q.send_break) begin
            s_d.tx_sh = 11'h000;
            s_d.brk_sent = 1'b1;
         end else if (s_q.brk_sent) begin
            s_d.tx_sh = 11'h7FF;
            s_d.tx_cnt = 4'h1;
            s_d.brk_sent = 1'b0;
         end else if (s_d.hold_full) begin
            s_d.tx_sh = {1'b1, s_q.word_len9 ? s_q.tx_ninth_bit : 1'b1, s_d.tx_hold_buffer,
                         1'b0};
            s_d.hold_full = 1'b0;
            s_d.tx_empty_flag = 1'b1;
         end else begin
            s_d.tst = TX_READY;
         end
      end
      if (s_d.tst != TX_SHIFT) begin
         s_d.tx_pin = 1'b1;
      end
      s_d.tx_oe = s_d.tx_enable || s_d.rx_enable;
      // ---------------------------------------------------------------
      // Receiver
      // ---------------------------------------------------------------
      os_t = 1'b0;
      if (!s_q.rx_enable) begin
         s_d.rx_div = 20'h0;
         s_d.rst = RX_HUNT;
         s_d.rx_prev = 1'b1;
      end else if (s_q.rx_div == div_lim(s_q.pr_sel, s_q.rx_div_sel, s_q.rx_fine_prescaler)) begin
         s_d.rx_div = 20'h0;
         os_t = 1'b1;
      end else begin
         s_d.rx_div = s_q.rx_div + 20'h1;
      end
      in_bit = serial_rx_in;
      v = {s_q.rx_vote, in_bit};
      maj = (v[2] & v[1]) | (v[2] & v[0]) | (v[1] & v[0]);
      noisy = !((v == 3'h7) || (v == 3'h0));
      if (os_t) begin
         s_d.rx_prev = in_bit;
         case (s_q.rst)
            RX_HUNT: begin
               if (s_q.rx_prev && !in_bit) begin
                  s_d.rst = RX_BITS;
                  s_d.rx_os = 4'h1;
                  s_d.rx_idx = 4'h0;
                  s_d.rx_noise = 1'b0;
               end
            end
            RX_BITS: begin
               s_d.rx_os = s_q.rx_os + 4'h1;
               if (s_q.rx_os >= `AST_SMP_A && s_q.rx_os < `AST_SMP_C) begin
                  s_d.rx_vote = v[1:0];
               end
               if (s_q.rx_os == `AST_SMP_C) begin
                  s_d.rx_noise = s_q.rx_noise | noisy;
                  if (s_q.rx_idx == 4'h0) begin
                     if (maj) begin
                        s_d.rst = RX_HUNT;
                        s_d.nf_hidden = 1'b1;
                     end
                  end else if (s_q.rx_idx == (s_q.word_len9 ? `AST_STOP9 : `AST_STOP8)) begin
                     rx_done = 1'b1;
                     stop_ok = maj;
                     s_d.rst = RX_HUNT;
                  end else begin
                     s_d.rx_sh = {maj, s_q.rx_sh[8:1]};
                  end
               end
               if (s_q.rx_os == `AST_OS_LAST) begin
                  s_d.rx_idx = s_q.rx_idx + 4'h1;
               end
            end
            default: begin
               s_d.rst = RX_HUNT;
            end
         endcase
      end
      if (rx_done) begin
         if (s_q.rx_full_flag) begin
            s_d.ovr_flag = 1'b1;
         end else begin
            s_d.rx_hold_buffer = s_q.word_len9 ? s_q.rx_sh[7:0] : s_q.rx_sh[8:1];
            if (s_q.word_len9) begin
               s_d.rx_ninth_bit = s_q.rx_sh[8];
            end
            s_d.rx_full_flag = 1'b1;
            s_d.noise_flag = s_d.rx_noise | s_q.nf_hidden;
            s_d.framing_error_flag = !stop_ok;
            s_d.nf_hidden = 1'b0;
         end
      end
      // ---------------------------------------------------------------
      // Interrupt request
      // ---------------------------------------------------------------
      s_d.irq = !cpu_irq_mask && ((s_d.tx_empty_flag && s_d.tx_empty_irq_en)
         || (s_d.tx_complete_flag && s_d.tx_complete_irq_en)
         || ((s_d.rx_full_flag || s_d.ovr_flag) && s_d.rx_irq_en));
      s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
      s_d.rsp.wready = !s_d.w_have && !s_d.rsp.bvalid;
      s_d.rsp.arready = !s_d.rsp.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.tst <= TX_OFF;
         s_q.rst <= RX_HUNT;
         s_q.tx_empty_flag <= 1'b1;
         s_q.tx_complete_flag <= 1'b1;
         s_q.tx_pin <= 1'b1;
         s_q.rx_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign axi_rsp = s_q.rsp;
   assign serial_tx_out = s_q.tx_pin;
   assign serial_tx_oe = s_q.tx_oe;
   assign irq = s_q.irq;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   line_idle_a: assert property (s_q.tst != TX_SHIFT |-> s_q.tx_pin)
      else $error("line not high while idle");
   pin_release_a: assert property (!s_q.tx_enable && !s_q.rx_enable |-> !s_q.tx_oe)
      else $error("pin held while disabled");
   direct_load_a: assert property (wr_data && s_q.tst == TX_READY && s_q.tx_enable
      && !s_q.idle_pend && !s_q.send_break && !s_q.brk_sent
      |=> s_q.tst == TX_SHIFT && s_q.tx_empty_flag && s_q.tx_cnt != 4'h0)
      else $error("idle write did not start frame");
   hold_store_a: assert property (wr_data && s_q.tst == TX_SHIFT
      && s_q.tx_enable == s_q.en_prev |=> s_q.hold_full)
      else $error("busy write not held");
   toggle_drop_a: assert property (s_q.tx_enable != s_q.en_prev |=> !s_q.hold_full)
      else $error("hold survived enable toggle");
   idle_queue_a: assert property (s_q.tx_enable && !s_q.en_prev |=> s_q.idle_pend
      || (s_q.tst == TX_SHIFT && s_q.tx_sh == 11'h7FF))
      else $error("no idle frame queued");
   tx_clear_a: assert property ($fell(s_q.tx_complete_flag) |-> $past(wr_data && s_q.seen))
      else $error("complete flag cleared without sequence");
   rx_clear_a: assert property ($fell(s_q.rx_full_flag) |-> $past(rd_data && s_q.seen))
      else $error("full flag cleared without sequence");
   rx_fill_a: assert property (rx_done && !s_q.rx_full_flag
      |=> s_q.rx_full_flag && s_q.framing_error_flag == !$past(stop_ok))
      else $error("received char not posted");
   overrun_keep_a: assert property (rx_done && s_q.rx_full_flag
      |=> s_q.ovr_flag && $stable(s_q.rx_hold_buffer))
      else $error("overrun handling wrong");
   irq_raise_a: assert property (s_q.rx_full_flag && s_q.rx_irq_en && !cpu_irq_mask
      && !$fell(s_q.rx_full_flag) |=> irq || !s_q.rx_full_flag || $rose(cpu_irq_mask))
      else $error("receive interrupt missing");

   tx_frame_c: cover property (s_q.tst == TX_SHIFT ##1 s_q.tst == TX_READY);
   rx_char_c: cover property (rx_done && !s_q.rx_full_flag);
   overrun_c: cover property (rx_done && s_q.rx_full_flag);
   break_c: cover property (s_q.brk_sent && !s_q.send_break);
endmodule : ast_top
`default_nettype wire

//--- bench/ast_peer.sv
`default_nettype none
module ast_peer (
   input wire logic aclk,
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT = 16;
   logic [8:0] got;
   logic got_stop;
   initial line_out = 1'h1;
   task automatic hold(input int n);
      repeat (n) @(posedge aclk);
   endtask : hold
   // Frame out, stop level and bit-0 glitch selectable
   task automatic send(input logic [8:0] d, input int n, input logic stp, input logic nz);
      line_out <= 1'h0;
      hold(BIT);
      for (int i = 0; i < n; i++) begin
         line_out <= d[i];
         if (nz && i == 0) begin
            hold(9);
            line_out <= ~d[0];
            hold(1);
            line_out <= d[0];
            hold(6);
         end else begin
            hold(BIT);
         end
      end
      line_out <= stp;
      hold(BIT);
      line_out <= 1'h1;
      hold(2 * BIT);
   endtask : send
   // Frame in, sampled mid-bit
   task automatic recv(input int n);
      got = '0;
      do hold(1); while (line_in !== 1'h0);
      hold(BIT / 2);
      for (int i = 0; i < n; i++) begin
         hold(BIT);
         got[i] = line_in;
      end
      hold(BIT);
      got_stop = line_in;
   endtask : recv
endmodule : ast_peer
`default_nettype wire

//--- bench/tb_top.sv
`include "ast_cfg.svh"
`default_nettype none
module tb_top import ast_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, cpu_irq_mask, serial_tx_out, serial_tx_oe, irq, serial_rx_in;
   ast_axi_req_t req;
   ast_axi_rsp_t rsp;
   int miscompares = 0;
   int comparisons = 0;
   int n;
   logic [31:0] rv;
   logic [1:0] rr;
   ast_top DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .serial_rx_in(serial_rx_in), .cpu_irq_mask(cpu_irq_mask),
      .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe), .irq(irq));
   ast_peer PEER (.aclk(aclk), .line_in(serial_tx_out), .line_out(serial_rx_in));
   task automatic final_report();
      if (miscompares == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      req.awvalid <= 1'h1;
      req.awaddr <= a;
      req.wvalid <= 1'h1;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'hF;
      req.bready <= 1'h1;
      fork
         begin
            do @(posedge aclk); while (rsp.awready !== 1'h1);
            req.awvalid <= 1'h0;
         end
         begin
            do @(posedge aclk); while (rsp.wready !== 1'h1);
            req.wvalid <= 1'h0;
         end
      join
      do @(posedge aclk); while (rsp.bvalid !== 1'h1);
      req.bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      req.arvalid <= 1'h1;
      req.araddr <= a;
      req.rready <= 1'h1;
      do @(posedge aclk); while (rsp.arready !== 1'h1);
      req.arvalid <= 1'h0;
      do @(posedge aclk); while (rsp.rvalid !== 1'h1);
      rv = rsp.rdata;
      rr = rsp.rresp;
      req.rready <= 1'h0;
   endtask : rd
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
   endtask : rdchk
   // Status, data, status after a received frame
   task automatic rxres(input logic [31:0] st, input logic [31:0] d);
      rdchk(`AST_A_STAT, st);
      rdchk(`AST_A_DATA, d);
      rdchk(`AST_A_STAT, 32'hC0);
   endtask : rxres
   initial begin
      aclk = 1'h0;
      forever #2.5 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      final_report();
   end
   initial begin
      req = '0;
      aresetn = 1'h0;
      cpu_irq_mask = 1'h0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      rdchk(`AST_A_STAT, 32'hC0);
      rd(8'h1C);
      chk({rv[29:0], rr}, 32'h2);
      wr(`AST_A_CR2, 8'h2C);
      @(posedge aclk);
      chk({30'h0, serial_tx_oe, serial_tx_out}, 32'h3);
      rdchk(`AST_A_STAT, 32'hC0);
      fork
         PEER.recv(8);
         begin
            wr(`AST_A_DATA, 8'hA5);
            n = 0;
            while (serial_tx_out === 1'h1 && n < 400) begin
               @(posedge aclk);
               n++;
            end
         end
      join
      chk({31'h0, n >= 128}, 32'h1);
      chk({22'h0, PEER.got, PEER.got_stop}, 32'h14B);
      repeat (16) @(posedge aclk);
      fork
         begin
            PEER.recv(8);
            chk({22'h0, PEER.got, PEER.got_stop}, 32'h79);
            PEER.recv(8);
            chk({23'h0, PEER.got}, 32'h5A);
         end
         begin
            rd(`AST_A_STAT);
            wr(`AST_A_DATA, 8'h3C);
            rdchk(`AST_A_STAT, 32'h80);
            wr(`AST_A_DATA, 8'h5A);
            rdchk(`AST_A_STAT, 32'h00);
         end
      join
      repeat (16) @(posedge aclk);
      rdchk(`AST_A_STAT, 32'hC0);
      wr(`AST_A_CR1, 8'h50);
      rdchk(`AST_A_STAT, 32'hC0);
      fork
         PEER.recv(9);
         wr(`AST_A_DATA, 8'h01);
      join
      chk({23'h0, PEER.got}, 32'h101);
      PEER.send(9'h196, 9, 1'h1, 1'h0);
      chk({31'h0, irq}, 32'h1);
      cpu_irq_mask <= 1'h1;
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      cpu_irq_mask <= 1'h0;
      rdchk(`AST_A_CR1, 32'hD0);
      rxres(32'hE0, 32'h96);
      wr(`AST_A_CR1, 8'h00);
      PEER.send(9'h011, 8, 1'h1, 1'h0);
      PEER.send(9'h022, 8, 1'h1, 1'h0);
      rxres(32'hE8, 32'h11);
      PEER.send(9'h000, 8, 1'h0, 1'h0);
      rxres(32'hE2, 32'h00);
      PEER.send(9'h055, 8, 1'h1, 1'h1);
      rxres(32'hE4, 32'h55);
      wr(`AST_A_CR2, 8'h2D);
      PEER.recv(8);
      chk({22'h0, PEER.got, PEER.got_stop}, 32'h0);
      wr(`AST_A_CR2, 8'h2C);
      repeat (400) @(posedge aclk);
      wr(`AST_A_CR2, 8'h00);
      @(posedge aclk);
      chk({31'h0, serial_tx_oe}, 32'h0);
      final_report();
   end
endmodule : tb_top
`default_nettype wire
